//--- hdl/bcm_pkg.sv
/*
 * Shared constants for the six-step commutation and PWM core: output
 * reset levels, sensor code tables for both phasings and the drive tables.
 * Assumes sensor codes are packed {sensor_1, sensor_2, sensor_3}, and that
 * phase vectors put phase 1 in bit 0.
 */
package bcm_pkg;

	localparam int BCM_STEPS = 6;

	// Analog trip level of the current-sense comparator, in millivolts
	localparam int BCM_ISENSE_MV = 100;

	// Reset values of the registers, plus the all-lows-on brake level
	localparam logic [2:0] BCM_HS_OFF_B = 3'h7;
	localparam logic [2:0] BCM_LS_OFF = 3'h0;
	localparam logic [2:0] BCM_LS_ALL_ON = 3'h7;
	localparam logic BCM_FAULT_RST_B = 1'h0;
	localparam logic BCM_LATCH_RST = 1'h0;

	// Codes that cannot occur with a healthy sensor set
	localparam logic [2:0] BCM_BAD60_A = 3'h5;
	localparam logic [2:0] BCM_BAD60_B = 3'h2;
	localparam logic [2:0] BCM_BAD120_A = 3'h7;
	localparam logic [2:0] BCM_BAD120_B = 3'h0;

	typedef logic [BCM_STEPS-1:0][2:0] bcm_table_type;

	// Sensor code of each step, index 0 is the first step
	localparam bcm_table_type BCM_CODE_60 = {3'h0, 3'h1, 3'h3, 3'h7, 3'h6, 3'h4};
	localparam bcm_table_type BCM_CODE_120 = {3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};

	// Forward drive: one-hot phase that conducts high and low in each step
	localparam bcm_table_type BCM_FWD_TOP = {3'h1, 3'h4, 3'h4, 3'h2, 3'h2, 3'h1};
	localparam bcm_table_type BCM_FWD_BOT = {3'h2, 3'h2, 3'h1, 3'h1, 3'h4, 3'h4};

endpackage

//--- hdl/bcm_commutation_core.sv
/*
 * Digital core of a three-phase brushless motor controller: rotor sensor
 * decode, six-step drive tables, brake and enable overrides, fault flag and
 * a dual-latch PWM with cycle-by-cycle current limiting.
 * Assumes every input is already synchronous to mclk; the oscillator ramp,
 * speed comparator and current comparator are analog and arrive as levels.
 */
// Notes on behaviour
// - Fault flag and high-side drives are active low.
// - Phasing select high decodes 60 degree sensors, low decodes 120 degree.
// - Invalid code, no brake: all drives off, fault asserted.
// - Invalid code, brake: highs off, all lows on, fault asserted.
// - Valid code, brake, enabled: highs off, lows on, fault inactive.
// - Valid code, brake, disabled: highs off, lows on, fault asserted.
// - Valid code, no brake, disabled: all drives off, fault asserted.
// - Valid, enabled, no brake, overcurrent: all drives off, fault asserted.
// - Overcurrent above the sense threshold asserts fault while it lasts.
// - Oscillator discharge sets both PWM latches at each cycle start.
// - Speed comparator resets upper latch, ending low-side conduction.
// - PWM gates only the low-side drives, never the high side.
// - Overcurrent resets lower latch, conduction off for rest of ramp.
// - Current limit is per cycle; next discharge restarts conduction.
// - At most one conduction pulse per oscillator cycle.
// - Brake overrides every other input at the drives, not at the fault flag, and shorts the windings.
// - Low-side braking waits until all high-side drives are off.
// - Valid codes step a six-step table; direction selects the table.
`timescale 1ns/1ps
`default_nettype none

module bcm_commutation_core
	import bcm_pkg::*;
(
	input wire logic mclk, // 100 MHz logic clock
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic rotor_sensor_1, // Rotor position sensor, phase 1
	input wire logic rotor_sensor_2, // Rotor position sensor, phase 2
	input wire logic rotor_sensor_3, // Rotor position sensor, phase 3
	input wire logic sel_60deg, // High: 60 degree phasing, low: 120 degree
	input wire logic dir_forward, // High: forward table, low: reverse
	input wire logic out_enable, // High: run, low: coast
	input wire logic brake, // High: dynamic brake
	input wire logic over_current, // Sense voltage above threshold
	input wire logic osc_discharge, // Timing ramp discharging
	input wire logic pwm_trip, // Ramp above speed demand
	output logic high_side_drive_1_b, // High-side drive phase 1, low = on
	output logic high_side_drive_2_b, // High-side drive phase 2, low = on
	output logic high_side_drive_3_b, // High-side drive phase 3, low = on
	output logic low_side_drive_1, // Low-side drive phase 1, high = on
	output logic low_side_drive_2, // Low-side drive phase 2, high = on
	output logic low_side_drive_3, // Low-side drive phase 3, high = on
	output logic fault_b, // Fault flag, low = fault
	output logic pwm_window // Both PWM latches set
);
	import bcm_pkg::*;

	logic [2:0] hs_b_q;
	logic [2:0] hs_b_d;
	logic [2:0] ls_q;
	logic [2:0] ls_d;
	logic fault_b_q;
	logic fault_b_d;
	logic upper_q;
	logic upper_d;
	logic lower_q;
	logic lower_d;

	wire [2:0] sensor_code = {rotor_sensor_1, rotor_sensor_2, rotor_sensor_3};

	// Step lookup: returns {valid, step index}
	function automatic logic [3:0] bcm_decode(input logic [2:0] code, input logic use60);
		logic [3:0] res;
		logic [2:0] ref_code;
		res = 4'h0;
		for (int i = 0; i < BCM_STEPS; i++)
		begin
			ref_code = use60 ? BCM_CODE_60[i] : BCM_CODE_120[i];
			if (ref_code == code)
			begin
				res = {1'b1, i[2:0]};
			end
		end
		return res;
	endfunction

	wire [3:0] decoded = bcm_decode(sensor_code, sel_60deg);
	wire code_valid = decoded[3];
	wire [2:0] step = decoded[2:0];

	// Reverse rotation swaps the high and low phase of every step
	wire [2:0] tbl_top = dir_forward ? BCM_FWD_TOP[step] : BCM_FWD_BOT[step];
	wire [2:0] tbl_bot = dir_forward ? BCM_FWD_BOT[step] : BCM_FWD_TOP[step];

	// Normal running: no override of any kind
	wire run = !brake && code_valid && out_enable && !over_current;
	wire hs_all_off = (hs_b_q == BCM_HS_OFF_B);

	// Reset dominates set, so a trip during discharge still blocks the cycle
	assign upper_d = pwm_trip ? 1'b0 : (osc_discharge ? 1'b1 : upper_q);
	assign lower_d = over_current ? 1'b0 : (osc_discharge ? 1'b1 : lower_q);
	wire pwm_on = upper_d && lower_d;

	// High side follows the table only; PWM never touches it
	assign hs_b_d = run ? ~tbl_top : BCM_HS_OFF_B;

	// Brake turns lows on only once the highs are seen off
	assign ls_d = brake ? (hs_all_off ? BCM_LS_ALL_ON : BCM_LS_OFF) :
		(run && pwm_on) ? tbl_bot : BCM_LS_OFF;

	assign fault_b_d = code_valid && out_enable && !over_current;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hs_b_q <= BCM_HS_OFF_B;
			ls_q <= BCM_LS_OFF;
			fault_b_q <= BCM_FAULT_RST_B;
			upper_q <= BCM_LATCH_RST;
			lower_q <= BCM_LATCH_RST;
		end
		else
		begin
			hs_b_q <= hs_b_d;
			ls_q <= ls_d;
			fault_b_q <= fault_b_d;
			upper_q <= upper_d;
			lower_q <= lower_d;
		end
	end

	assign high_side_drive_1_b = hs_b_q[0];
	assign high_side_drive_2_b = hs_b_q[1];
	assign high_side_drive_3_b = hs_b_q[2];
	assign low_side_drive_1 = ls_q[0];
	assign low_side_drive_2 = ls_q[1];
	assign low_side_drive_3 = ls_q[2];
	assign fault_b = fault_b_q;
	assign pwm_window = upper_q && lower_q;

	chk_brake_no_overlap: assert property (@(posedge mclk) disable iff (!rst_b)
		(ls_q == BCM_LS_ALL_ON) |-> $past(hs_b_q) == BCM_HS_OFF_B)
		else $error("low side braked before high side was off");

	chk_brake_shorts: assert property (@(posedge mclk) disable iff (!rst_b)
		brake [*2] |=> (ls_q == BCM_LS_ALL_ON && hs_b_q == BCM_HS_OFF_B))
		else $error("held brake did not short the windings");

	chk_invalid_off: assert property (@(posedge mclk) disable iff (!rst_b)
		(!brake && !code_valid) |=> (hs_b_q == BCM_HS_OFF_B && ls_q == BCM_LS_OFF && !fault_b))
		else $error("invalid code did not stop drives");

	chk_invalid_brake: assert property (@(posedge mclk) disable iff (!rst_b)
		(brake && !code_valid) |=> (hs_b_q == BCM_HS_OFF_B && !fault_b))
		else $error("invalid code under brake wrong");

	chk_brake_fault: assert property (@(posedge mclk) disable iff (!rst_b)
		(brake && code_valid && out_enable && !over_current) |=> fault_b)
		else $error("fault asserted during clean brake");

	chk_brake_disabled: assert property (@(posedge mclk) disable iff (!rst_b)
		(brake && code_valid && !out_enable) |=> (!fault_b && hs_b_q == BCM_HS_OFF_B))
		else $error("disabled brake fault missing");

	chk_disable_coast: assert property (@(posedge mclk) disable iff (!rst_b)
		(!brake && code_valid && !out_enable) |=>
		(ls_q == BCM_LS_OFF && hs_b_q == BCM_HS_OFF_B && !fault_b))
		else $error("disable did not coast");

	chk_oc_stop: assert property (@(posedge mclk) disable iff (!rst_b)
		over_current |=> (!fault_b && !lower_q && (brake || $past(brake) || ls_q == BCM_LS_OFF)))
		else $error("overcurrent did not stop drive");

	chk_hs_no_pwm: assert property (@(posedge mclk) disable iff (!rst_b)
		run |=> hs_b_q == ~$past(tbl_top))
		else $error("high side not following table");

	chk_cycle_set: assert property (@(posedge mclk) disable iff (!rst_b)
		(osc_discharge && !pwm_trip && !over_current) |=> (upper_q && lower_q))
		else $error("discharge did not set latches");

	chk_one_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
		(!upper_q && !osc_discharge) |=> !upper_q)
		else $error("second pulse in one cycle");

	chk_limit_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		(!lower_q && !osc_discharge) |=> !lower_q)
		else $error("current limit released early");

	chk_phasing: assert property (@(posedge mclk) disable iff (!rst_b)
		(sel_60deg ? (sensor_code == BCM_BAD60_A || sensor_code == BCM_BAD60_B) :
		(sensor_code == BCM_BAD120_A || sensor_code == BCM_BAD120_B)) |-> !code_valid)
		else $error("invalid code decoded as valid");

	// Drive tables, output polarity and sensor decode
	chk_hs_onehot: assert property (@(posedge mclk) disable iff (!rst_b)
		(hs_b_q != BCM_HS_OFF_B) |-> $onehot(~hs_b_q))
		else $error("more than one high side on");

	chk_ls_onehot: assert property (@(posedge mclk) disable iff (!rst_b)
		(ls_q != BCM_LS_OFF && ls_q != BCM_LS_ALL_ON) |-> $onehot(ls_q))
		else $error("more than one low side on while running");

	chk_phase_no_short: assert property (@(posedge mclk) disable iff (!rst_b)
		(~hs_b_q & ls_q) == 3'h0)
		else $error("high and low side of one phase both on");

	chk_fwd_top: assert property (@(posedge mclk) disable iff (!rst_b)
		(run && dir_forward) |=> hs_b_q == ~BCM_FWD_TOP[$past(step)])
		else $error("forward high side not from table");

	chk_rev_top: assert property (@(posedge mclk) disable iff (!rst_b)
		(run && !dir_forward) |=> hs_b_q == ~BCM_FWD_BOT[$past(step)])
		else $error("reverse high side not from table");

	chk_fwd_bot: assert property (@(posedge mclk) disable iff (!rst_b)
		(run && pwm_on && dir_forward) |=> ls_q == BCM_FWD_BOT[$past(step)])
		else $error("forward low side not from table");

	chk_rev_bot: assert property (@(posedge mclk) disable iff (!rst_b)
		(run && pwm_on && !dir_forward) |=> ls_q == BCM_FWD_TOP[$past(step)])
		else $error("reverse low side not from table");

	chk_decode_round: assert property (@(posedge mclk) disable iff (!rst_b)
		code_valid |-> sensor_code == (sel_60deg ? BCM_CODE_60[step] : BCM_CODE_120[step]))
		else $error("step does not match sensor code");

	chk_valid_codes: assert property (@(posedge mclk) disable iff (!rst_b)
		(sel_60deg ? (sensor_code != BCM_BAD60_A && sensor_code != BCM_BAD60_B) :
		(sensor_code != BCM_BAD120_A && sensor_code != BCM_BAD120_B)) |-> code_valid)
		else $error("valid code not decoded");

	chk_step_range: assert property (@(posedge mclk) disable iff (!rst_b)
		code_valid |-> int'(step) < BCM_STEPS)
		else $error("step index out of range");

	// PWM latches
	chk_trip_blocks: assert property (@(posedge mclk) disable iff (!rst_b)
		pwm_trip |=> (!upper_q && !pwm_window))
		else $error("speed trip did not clear upper latch");

	chk_trip_dominates: assert property (@(posedge mclk) disable iff (!rst_b)
		(pwm_trip && osc_discharge) |=> !pwm_window)
		else $error("discharge won over speed trip");

	chk_oc_window: assert property (@(posedge mclk) disable iff (!rst_b)
		over_current |=> !pwm_window)
		else $error("overcurrent left PWM window open");

	chk_discharge_lower: assert property (@(posedge mclk) disable iff (!rst_b)
		(!lower_q && osc_discharge && !over_current) |=> lower_q)
		else $error("next cycle did not rearm current limit");

	chk_window_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		(!pwm_window && !osc_discharge) |=> !pwm_window)
		else $error("PWM window reopened without discharge");

	chk_window_on_drive: assert property (@(posedge mclk) disable iff (!rst_b)
		(!$past(brake) && ls_q != BCM_LS_OFF) |-> pwm_window)
		else $error("low side on outside PWM window");

	chk_ls_gated: assert property (@(posedge mclk) disable iff (!rst_b)
		(!brake && !pwm_on) |=> ls_q == BCM_LS_OFF)
		else $error("low side on with PWM off");

	chk_ls_follow_table: assert property (@(posedge mclk) disable iff (!rst_b)
		(run && pwm_on) |=> ls_q == $past(tbl_bot))
		else $error("low side not from table in window");

	chk_hs_ignores_pwm: assert property (@(posedge mclk) disable iff (!rst_b)
		(run && !pwm_on) |=> hs_b_q != BCM_HS_OFF_B)
		else $error("high side gated by PWM");

	// Overrides and fault flag
	chk_fault_release: assert property (@(posedge mclk) disable iff (!rst_b)
		(code_valid && out_enable && !over_current) |=> fault_b)
		else $error("fault flag held without cause");

	chk_invalid_fault: assert property (@(posedge mclk) disable iff (!rst_b)
		!code_valid |=> !fault_b)
		else $error("invalid code without fault");

	chk_oc_drives_off: assert property (@(posedge mclk) disable iff (!rst_b)
		(over_current && !brake) |=> (hs_b_q == BCM_HS_OFF_B && ls_q == BCM_LS_OFF))
		else $error("overcurrent left a drive on");

	chk_idle_lows_off: assert property (@(posedge mclk) disable iff (!rst_b)
		(!brake && !run) |=> ls_q == BCM_LS_OFF)
		else $error("low side on while not running");

	chk_brake_highs_off: assert property (@(posedge mclk) disable iff (!rst_b)
		brake |=> hs_b_q == BCM_HS_OFF_B)
		else $error("brake left a high side on");

	chk_brake_run_lows: assert property (@(posedge mclk) disable iff (!rst_b)
		(brake && code_valid && out_enable && !over_current) [*2] |=>
		(ls_q == BCM_LS_ALL_ON && fault_b))
		else $error("clean brake did not short windings");

	chk_brake_off_lows: assert property (@(posedge mclk) disable iff (!rst_b)
		(brake && code_valid && !out_enable) [*2] |=> (ls_q == BCM_LS_ALL_ON && !fault_b))
		else $error("disabled brake did not short windings");

	chk_invalid_brake_lows: assert property (@(posedge mclk) disable iff (!rst_b)
		(brake && !code_valid) [*2] |=> ls_q == BCM_LS_ALL_ON)
		else $error("invalid code brake did not short windings");

endmodule

`default_nettype wire

//--- test/bcm_hall_model.sv
/*
 * Rotor sensor model: gives the sensor code of one of six rotor steps for
 * either phasing, or one of the two codes a broken sensor set can give.
 * Assumes step stays within 0 to 5.
 */
`timescale 1ns/1ps
`default_nettype none
module bcm_hall_model
(
	input wire logic sel_60deg, // High: 60 degree phasing
	input wire logic [2:0] step, // Rotor step 0 to 5
	input wire logic bad, // Give an impossible code, step[0] picks which
	output logic rotor_sensor_1, // Sensor phase 1
	output logic rotor_sensor_2, // Sensor phase 2
	output logic rotor_sensor_3 // Sensor phase 3
);
	localparam logic [2:0] C60 [6] = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
	localparam logic [2:0] C120 [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
	wire logic [2:0] bad_code = sel_60deg ? (step[0] ? 3'h2 : 3'h5) : (step[0] ? 3'h0 : 3'h7);
	wire logic [2:0] good_code = sel_60deg ? C60[step] : C120[step];
	assign {rotor_sensor_1, rotor_sensor_2, rotor_sensor_3} = bad ? bad_code : good_code;
endmodule
`default_nettype wire

//--- test/bldc_commutation_pwm_control_bench.sv
/*
 * Bench for the commutation and PWM core: walks all steps, phasings and
 * directions, PWM trip, current limit, brake, coast and bad sensor codes.
 * Assumes one-cycle registered outputs and a two-cycle brake entry.
 */
`timescale 1ns/1ps
`default_nettype none
module bldc_commutation_pwm_control_bench;
	logic mclk = 0, rst_b = 0, sel = 0, dir = 0, en = 0, brk = 0, oc = 0, dis = 0, trip = 0, inv = 0;
	logic [2:0] step = 0;
	logic [2:0] t, b;
	wire logic s1, s2, s3, h1, h2, h3, l1, l2, l3, fb, pw;
	wire logic [7:0] obs = {pw, fb, l3, l2, l1, h3, h2, h1};
	localparam logic [2:0] TOP_PH [6] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h1};
	localparam logic [2:0] BOT_PH [6] = '{3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h2};
	int bad_count = 0, checks_done = 0;
	always #5 mclk = ~mclk;
	bcm_hall_model hall (.sel_60deg(sel), .step(step), .bad(inv), .rotor_sensor_1(s1),
		.rotor_sensor_2(s2), .rotor_sensor_3(s3));
	bcm_commutation_core dut (.mclk(mclk), .rst_b(rst_b), .rotor_sensor_1(s1),
		.rotor_sensor_2(s2), .rotor_sensor_3(s3), .sel_60deg(sel), .dir_forward(dir),
		.out_enable(en), .brake(brk), .over_current(oc), .osc_discharge(dis), .pwm_trip(trip),
		.high_side_drive_1_b(h1), .high_side_drive_2_b(h2), .high_side_drive_3_b(h3),
		.low_side_drive_1(l1), .low_side_drive_2(l2), .low_side_drive_3(l3),
		.fault_b(fb), .pwm_window(pw));
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e)
		begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			bad_count++;
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task pulse;
		dis = 1;
		tick(1);
		dis = 0;
		tick(2);
	endtask
	initial
	begin
		tick(8);
		chk("reset", obs, 8'h07);
		rst_b = 1;
		en = 1;
		for (int i = 0; i < 32; i++)
		begin
			sel = i[4];
			dir = i[3];
			step = 3'(i % 6);
			pulse();
			t = dir ? TOP_PH[step] : BOT_PH[step];
			b = dir ? BOT_PH[step] : TOP_PH[step];
			chk("step", obs, {2'h3, b, ~t});
			trip = 1;
			tick(2);
			chk("trip", obs, {2'h1, 3'h0, ~t});
			trip = 0;
			tick(2);
			chk("one_pulse", obs, {2'h1, 3'h0, ~t});
		end
		step = 0;
		pulse();
		oc = 1;
		tick(2);
		chk("oc", obs, 8'h07);
		oc = 0;
		tick(2);
		chk("oc_hold", obs, 8'h46);
		trip = 1;
		pulse();
		chk("trip_dom", obs, 8'h46);
		trip = 0;
		pulse();
		chk("oc_next", obs, 8'he6);
		brk = 1;
		tick(1);
		chk("brk_first", {1'h0, obs[6:0]}, 8'h47);
		tick(1);
		chk("brk", {1'h0, obs[6:0]}, 8'h7f);
		en = 0;
		tick(2);
		chk("brk_off", {1'h0, obs[6:0]}, 8'h3f);
		brk = 0;
		tick(2);
		chk("coast", {1'h0, obs[6:0]}, 8'h07);
		en = 1;
		inv = 1;
		for (int i = 0; i < 4; i++)
		begin
			sel = i[1];
			step = 3'(i[0]);
			tick(2);
			chk("bad_code", {1'h0, obs[6:0]}, 8'h07);
			brk = 1;
			tick(2);
			chk("bad_brk", {1'h0, obs[6:0]}, 8'h3f);
			brk = 0;
		end
		rst_b = 0;
		inv = 0;
		step = 0;
		tick(1);
		chk("reset2", obs, 8'h07);
		rst_b = 1;
		tick(2);
		chk("restart", obs, 8'h46);
		summarize();
	end
endmodule
`default_nettype wire
